// ==== rtl/pmc_regs.sv ====
`timescale 1ns/100ps
module pmc_regs
   import pmc_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // Processor bus
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wr_data,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [7:0]  rd_data,
   // Datapath events and sub-block interrupt levels
   input  wire pmc_events_t events,
   input  wire logic [4:0]  block_irq,
   input  wire logic        rx_recovery_bypass,
   // Foreign clock pins
   input  wire logic        rx_ref_clk,
   input  wire logic        tx_ref_clk,
   input  wire logic        rx_out_clk,
   input  wire logic        tx_out_clk,
   // Controls and interrupt
   output pmc_ctrl_t        ctrl,
   output logic             irq_out_n
);

   // Assertion clock and reset for the whole module
   default clocking chk_clk @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // Software-written control state
   logic       soft_reset_bit;       // Holds framing in standby
   logic [6:1] config_bits;          // Auto inserts and polarities
   logic       cell_delin_loss_irq_en;
   logic       fixed_pointer_en;
   logic [2:0] loop_bits;            // Line, diag, loop timing
   logic [1:0] tx_synth_bits;        // Irq enable, ref select
   logic [1:0] rx_recov_bits;        // Irq enable, ref select
   logic       descrambler_disable;
   logic [3:0] section_irq_en;       // Parity, LOS, LOF, OOF

   // Sticky latches
   logic       tx_unlock_irq;
   logic       cell_delin_loss_irq;
   logic       rx_unlock_irq;
   logic [4:0] sect_latch;           // Ident, parity, LOS, LOF, OOF changes

   // Previous alarm levels for change detect
   logic       prev_cdl;
   logic [2:0] prev_sect;            // LOS, LOF, OOF
   logic       prev_tx_unlock;
   logic       prev_rx_unlock;

   // Decoded bus strobes
   wire        wr_master  = wr_en && addr == OFS_MASTER_RESET;
   wire        wr_config  = wr_en && addr == OFS_DEVICE_CONFIG;
   wire        wr_mctrl   = wr_en && addr == OFS_MASTER_CONTROL;
   wire        wr_txs     = wr_en && addr == OFS_TX_SYNTH;
   wire        wr_rxr     = wr_en && addr == OFS_RX_RECOVERY;
   wire        wr_sctrl   = wr_en && addr == OFS_RX_SECT_CTRL;
   wire        wr_cnt     = wr_en && (addr == OFS_PARITY_CNT_LO || addr == OFS_PARITY_CNT_HI);
   wire        rd_summary = rd_en && addr == OFS_IRQ_SUMMARY;
   wire        rd_clkmon  = rd_en && addr == OFS_CLOCK_ACTIVITY;
   wire        rd_sstat   = rd_en && addr == OFS_RX_SECT_STAT;

   wire        poll = wr_cnt | wr_master;

   // Event edges
   wire [2:0]  live_sect = {events.signal_loss, events.frame_loss, events.frame_slip};
   wire [2:0]  sect_chg  = live_sect ^ prev_sect;
   wire        cdl_chg   = events.cell_delin_loss ^ prev_cdl;
   wire        tx_ul_set = events.tx_unlock & ~prev_tx_unlock;
   wire        rx_ul_set = events.rx_unlock & ~prev_rx_unlock;
   wire [4:0]  sect_set  = {events.ident_err, events.parity_err, sect_chg};

   // Clock monitors and counter
   wire [3:0]  clk_seen;
   wire [15:0] section_parity_count;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_mon
         pmc_edge_monitor u_mon (
            .core_clk (core_clk),
            .rst      (rst),
            .mon_clk  (gi == 3 ? rx_ref_clk : gi == 2 ? tx_ref_clk :
                       gi == 1 ? rx_out_clk : tx_out_clk),
            .clear    (rd_clkmon),
            .seen     (clk_seen[gi])
         );
      end
   endgenerate

   pmc_err_counter #(.WIDTH(16)) u_cnt (
      .core_clk (core_clk),
      .rst      (rst),
      .err      (events.parity_err),
      .poll     (poll),
      .held     (section_parity_count)
   );

   // Read mux
   logic [7:0] next_rd_data;
   always_comb begin
      next_rd_data = 8'h00;
      unique case (addr)
         OFS_MASTER_RESET:   next_rd_data = {soft_reset_bit, RST_TYPE_CODE, RST_REVISION_CODE};
         OFS_DEVICE_CONFIG:  next_rd_data = {1'b0, config_bits, 1'b0};
         OFS_IRQ_SUMMARY:    next_rd_data = {tx_unlock_irq, cell_delin_loss_irq,
                                             rx_unlock_irq, block_irq};
         OFS_CLOCK_ACTIVITY: next_rd_data = {4'h0, clk_seen};
         OFS_MASTER_CONTROL: next_rd_data = {cell_delin_loss_irq_en, events.cell_delin_loss,
                                             fixed_pointer_en, 2'b00, loop_bits};
         OFS_TX_SYNTH:       next_rd_data = {4'h0, events.tx_unlock, 1'b0, tx_synth_bits};
         OFS_RX_RECOVERY:    next_rd_data = {4'h0, events.rx_unlock, 1'b0, rx_recov_bits};
         // Force bit is write-only, reads zero
         OFS_RX_SECT_CTRL:   next_rd_data = {1'b0, descrambler_disable, 2'b00, section_irq_en};
         OFS_RX_SECT_STAT:   next_rd_data = {sect_latch, live_sect};
         OFS_PARITY_CNT_LO:  next_rd_data = section_parity_count[7:0];
         OFS_PARITY_CNT_HI:  next_rd_data = section_parity_count[15:8];
         default:            next_rd_data = 8'h00;
      endcase
   end

   // Registered read data
   always_ff @(posedge core_clk) begin
      if (rst) rd_data <= 8'h00;
      else     rd_data <= next_rd_data;
   end

   // Software writes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         soft_reset_bit         <= RST_MASTER_RESET[BIT_SOFT_RESET];
         config_bits            <= RST_ZERO[6:1];
         cell_delin_loss_irq_en <= RST_MASTER_CTRL[BIT_CDL_IRQ_EN];
         fixed_pointer_en       <= RST_MASTER_CTRL[BIT_FIXED_PTR];
         loop_bits              <= RST_MASTER_CTRL[2:0];
         tx_synth_bits          <= RST_ZERO[1:0];
         rx_recov_bits          <= RST_ZERO[1:0];
         descrambler_disable    <= RST_ZERO[BIT_DESCR_DIS];
         section_irq_en         <= RST_ZERO[3:0];
      end else begin
         if (wr_master) soft_reset_bit <= wr_data[BIT_SOFT_RESET];
         if (wr_config) config_bits <= wr_data[6:1];
         if (wr_mctrl) begin
            cell_delin_loss_irq_en <= wr_data[BIT_CDL_IRQ_EN];
            fixed_pointer_en       <= wr_data[BIT_FIXED_PTR];
            loop_bits              <= wr_data[2:0];
         end
         if (wr_txs) tx_synth_bits <= wr_data[1:0];
         if (wr_rxr) rx_recov_bits <= wr_data[1:0];
         if (wr_sctrl) begin
            descrambler_disable <= wr_data[BIT_DESCR_DIS];
            section_irq_en      <= wr_data[3:0];
         end
      end
   end

   // Sticky latches, set wins over read clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tx_unlock_irq       <= 1'b0;
         cell_delin_loss_irq <= 1'b0;
         rx_unlock_irq       <= 1'b0;
         sect_latch          <= 5'h00;
         prev_cdl            <= 1'b0;
         prev_sect           <= 3'h0;
         prev_tx_unlock      <= 1'b0;
         prev_rx_unlock      <= 1'b0;
      end else begin
         tx_unlock_irq       <= tx_ul_set | (tx_unlock_irq & ~rd_summary);
         cell_delin_loss_irq <= cdl_chg | (cell_delin_loss_irq & ~rd_summary);
         rx_unlock_irq       <= rx_ul_set | (rx_unlock_irq & ~rd_summary);
         sect_latch          <= sect_set | (sect_latch & {5{~rd_sstat}});
         prev_cdl            <= events.cell_delin_loss;
         prev_sect           <= live_sect;
         prev_tx_unlock      <= events.tx_unlock;
         prev_rx_unlock      <= events.rx_unlock;
      end
   end

   // Pending enabled interrupts; ident latch has no enable so it is always live
   wire sect_pending = sect_latch[4] | |(sect_latch[3:0] & section_irq_en);
   wire any_pending  = (tx_unlock_irq & tx_synth_bits[BIT_UNLOCK_IRQEN])
                     | (rx_unlock_irq & rx_recov_bits[BIT_UNLOCK_IRQEN])
                     | (cell_delin_loss_irq & cell_delin_loss_irq_en)
                     | sect_pending | |block_irq;

   // Transmit clock choice
   wire [1:0] tx_src = !loop_bits[BIT_LOOP_TIMING] ? TXCLK_SYNTH :
                       rx_recovery_bypass ? TXCLK_RX_REF : TXCLK_RECOVERED;

   // Registered controls and interrupt pin
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl      <= '0;
         irq_out_n <= 1'b1;
      end else begin
         irq_out_n <= ~any_pending;
         ctrl.far_error_insert       <= config_bits[BIT_AUTO_FAR] & events.line_path_err;
         ctrl.line_defect_insert     <= config_bits[BIT_AUTO_LINE] &
                                        (events.signal_loss | events.frame_loss | events.line_ais);
         ctrl.path_defect_insert     <= config_bits[BIT_AUTO_PATH] &
                                        (events.signal_loss | events.frame_loss | events.line_ais |
                                         events.ptr_loss | events.path_ais |
                                         events.cell_delin_loss);
         ctrl.tx_cell_avail_polarity <= config_bits[BIT_TX_CA_POL];
         ctrl.rx_cell_avail_polarity <= config_bits[BIT_RX_CA_POL];
         ctrl.serial_in_polarity     <= config_bits[BIT_SERIAL_POL];
         ctrl.fixed_pointer_en       <= fixed_pointer_en;
         ctrl.line_loopback_en       <= loop_bits[BIT_LINE_LOOP];
         ctrl.diag_loopback_en       <= loop_bits[BIT_DIAG_LOOP];
         ctrl.tx_clk_sel             <= tx_src;
         ctrl.tx_ref_freq_sel        <= tx_synth_bits[BIT_REF_SEL];
         ctrl.rx_ref_freq_sel        <= rx_recov_bits[BIT_REF_SEL];
         ctrl.descrambler_disable    <= descrambler_disable;
         ctrl.force_framer_resync    <= wr_sctrl & wr_data[BIT_FORCE_RESYNC];
         ctrl.framing_reset          <= soft_reset_bit;
         ctrl.counter_poll           <= wr_master;
      end
   end

   sequence cdl_latched_s;
      cdl_chg ##1 cell_delin_loss_irq;
   endsequence

   sequence standby_steps_s;
      soft_reset_bit ##1 ctrl.framing_reset;
   endsequence

   tx_set_a: assert property (tx_ul_set |=> tx_unlock_irq)
      else $error("tx unlock missed");

   summary_clr_a: assert property (rd_summary && !tx_ul_set |=> !tx_unlock_irq)
      else $error("tx unlock not cleared");

   cdl_set_a: assert property (cdl_chg |-> cdl_latched_s)
      else $error("cdl change missed");

   rx_unlock_a: assert property (rx_ul_set |=> rx_unlock_irq)
      else $error("rx unlock missed");

   far_insert_a: assert property (
      events.line_path_err && config_bits[BIT_AUTO_FAR] |=> ctrl.far_error_insert)
      else $error("far error not inserted");

   line_insert_a: assert property (
      config_bits[BIT_AUTO_LINE] && (events.signal_loss || events.line_ais)
      |=> ctrl.line_defect_insert) else $error("line defect not inserted");

   path_insert_a: assert property (
      config_bits[BIT_AUTO_PATH] && (events.ptr_loss || events.path_ais)
      |=> ctrl.path_defect_insert) else $error("path defect not inserted");

   irq_pin_a: assert property (any_pending |=> !irq_out_n)
      else $error("irq pin not asserted");

   irq_idle_a: assert property (!any_pending |=> irq_out_n)
      else $error("irq pin not released");

   // force only on write; back-to-back writes may hold it
   force_pulse_a: assert property (
      !(wr_sctrl && wr_data[BIT_FORCE_RESYNC]) |=> !ctrl.force_framer_resync)
      else $error("force not pulse");

   soft_reset_a: assert property (
      wr_master && wr_data[BIT_SOFT_RESET] |=> standby_steps_s)
      else $error("soft reset not applied");

   loop_src_a: assert property (
      !loop_bits[BIT_LOOP_TIMING] |=> ctrl.tx_clk_sel == TXCLK_SYNTH)
      else $error("tx clock source wrong");

   poll_pulse_a: assert property (wr_master |=> ctrl.counter_poll)
      else $error("poll pulse missed");

   summary_rd_a: assert property (
      addr == OFS_IRQ_SUMMARY |=> rd_data[4:0] == $past(block_irq))
      else $error("summary bits wrong");

endmodule

// ==== rtl/pmc_pkg.sv ====
package pmc_pkg;

   // Register offsets on the 8-bit processor bus
   localparam logic [7:0] OFS_MASTER_RESET   = 8'h00;
   localparam logic [7:0] OFS_DEVICE_CONFIG  = 8'h01;
   localparam logic [7:0] OFS_IRQ_SUMMARY    = 8'h02;
   localparam logic [7:0] OFS_CLOCK_ACTIVITY = 8'h04;
   localparam logic [7:0] OFS_MASTER_CONTROL = 8'h05;
   localparam logic [7:0] OFS_TX_SYNTH       = 8'h06;
   localparam logic [7:0] OFS_RX_RECOVERY    = 8'h07;
   localparam logic [7:0] OFS_RX_SECT_CTRL   = 8'h10;
   localparam logic [7:0] OFS_RX_SECT_STAT   = 8'h11;
   localparam logic [7:0] OFS_PARITY_CNT_LO  = 8'h12;
   localparam logic [7:0] OFS_PARITY_CNT_HI  = 8'h13;

   // Bit positions
   localparam int BIT_SOFT_RESET   = 7;
   localparam int BIT_AUTO_FAR     = 6;
   localparam int BIT_AUTO_LINE    = 5;
   localparam int BIT_AUTO_PATH    = 4;
   localparam int BIT_TX_CA_POL    = 3;
   localparam int BIT_RX_CA_POL    = 2;
   localparam int BIT_SERIAL_POL   = 1;
   localparam int BIT_CDL_IRQ_EN   = 7;
   localparam int BIT_CDL_STATUS   = 6;
   localparam int BIT_FIXED_PTR    = 5;
   localparam int BIT_LINE_LOOP    = 2;
   localparam int BIT_DIAG_LOOP    = 1;
   localparam int BIT_LOOP_TIMING  = 0;
   localparam int BIT_UNLOCK_STAT  = 3;
   localparam int BIT_UNLOCK_IRQEN = 1;
   localparam int BIT_REF_SEL      = 0;
   localparam int BIT_DESCR_DIS    = 6;
   localparam int BIT_FORCE_RESYNC = 5;

   // Reset values
   localparam logic [7:0] RST_MASTER_RESET  = 8'h30;
   localparam logic [7:0] RST_MASTER_CTRL   = 8'h20;
   localparam logic [7:0] RST_ZERO          = 8'h00;
   localparam logic [2:0] RST_TYPE_CODE     = 3'h0;  // Arbitrary value
   localparam logic [3:0] RST_REVISION_CODE = 4'h0;  // Arbitrary value

   // Timing: bit periods without transitions before receive unlock
   localparam int NO_TRANSITION_BITS = 80;
   localparam int LOCK_TOL_PPM       = 244;
   localparam int FIXED_POINTER      = 522;
   localparam logic [9:0] FIXED_PTR_VALUE = 10'h20a;

   // Raw events from the sonet datapath, one-cycle pulses or levels
   typedef struct packed {
      logic tx_unlock;      // Level: synthesizer unlocked
      logic rx_unlock;      // Level: recovery unlocked or idle input
      logic cell_delin_loss; // Level: cell delineation lost
      logic signal_loss;    // Level
      logic frame_loss;     // Level
      logic frame_slip;     // Level (out of frame)
      logic parity_err;     // Pulse: section parity error
      logic ident_err;      // Pulse: identification bytes out of order
      logic line_path_err;  // Pulse: line or path parity error
      logic line_ais;       // Level
      logic ptr_loss;       // Level
      logic path_ais;       // Level
   } pmc_events_t;

   // Control outputs into the datapath
   typedef struct packed {
      logic       far_error_insert;
      logic       line_defect_insert;
      logic       path_defect_insert;
      logic       tx_cell_avail_polarity;
      logic       rx_cell_avail_polarity;
      logic       serial_in_polarity;
      logic       fixed_pointer_en;
      logic       line_loopback_en;
      logic       diag_loopback_en;
      logic [1:0] tx_clk_sel;
      logic       tx_ref_freq_sel;
      logic       rx_ref_freq_sel;
      logic       descrambler_disable;
      logic       force_framer_resync;
      logic       framing_reset;
      logic       counter_poll;
   } pmc_ctrl_t;

   // Transmit clock source choices
   localparam logic [1:0] TXCLK_SYNTH     = 2'h0;
   localparam logic [1:0] TXCLK_RECOVERED = 2'h1;
   localparam logic [1:0] TXCLK_RX_REF    = 2'h2;

endpackage

// ==== rtl/pmc_edge_monitor.sv ====
`timescale 1ns/100ps
// Sticky activity flag for a foreign clock, sampled through two flops
module pmc_edge_monitor
   import pmc_pkg::*;
(
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst,
   // Monitored clock pin and clear strobe
   input  wire logic mon_clk,
   input  wire logic clear,
   // Sticky flag
   output logic      seen
);

   logic sync_a;   // First synchroniser stage
   logic sync_b;   // Second stage
   logic sync_c;   // Delayed copy for edge detect
   wire  rise = sync_b & ~sync_c;

   // Synchroniser; monitored clock must be well below core rate
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         sync_c <= 1'b0;
      end else begin
         sync_a <= mon_clk;
         sync_b <= sync_a;
         sync_c <= sync_b;
      end
   end

   // Set wins over the read clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         seen <= 1'b0;
      end else begin
         seen <= rise | (seen & ~clear);
      end
   end

   seen_set_a: assert property (@(posedge core_clk) disable iff (rst)
      rise |=> seen) else $error("edge did not set flag");

endmodule

// ==== rtl/pmc_err_counter.sv ====
`timescale 1ns/100ps
// Saturating error counter with lossless poll into a holding register
module pmc_err_counter
   import pmc_pkg::*;
#(
   parameter int WIDTH = 16
)(
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // Error pulse and poll strobe
   input  wire logic             err,
   input  wire logic             poll,
   // Held count for software
   output logic [WIDTH-1:0]      held
);

   logic [WIDTH-1:0] count;   // Running accumulator
   wire              at_max = &count;
   wire [WIDTH-1:0]  bumped = at_max ? count : count + 1'b1;

   // Poll copies and restarts; a coincident error counts into the new period
   always_ff @(posedge core_clk) begin
      if (rst) begin
         count <= '0;
         held  <= '0;
      end else if (poll) begin
         held  <= count;
         count <= err ? {{(WIDTH-1){1'b0}}, 1'b1} : '0;
      end else begin
         count <= err ? bumped : count;
      end
   end

   poll_keeps_a: assert property (@(posedge core_clk) disable iff (rst)
      poll && err |=> count == 1) else $error("coincident error lost");

endmodule

// ==== tb/pmc_regs_tb.sv ====
`timescale 1ns/100ps
module pmc_regs_tb;
   import pmc_pkg::*;

   // Bench-driven inputs
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wr_data = 8'h00;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   pmc_events_t events = '0;
   logic [4:0]  block_irq = 5'h00;
   logic        byp = 1'b0;    // Receive recovery bypass
   logic [3:0]  fclk = 4'h0;   // Foreign clocks: rx ref, tx ref, rx out, tx out
   // Observed outputs
   logic [7:0]  rd_data;
   pmc_ctrl_t   ctrl;
   logic        irq_out_n;
   // Score
   int          num_errors = 0;
   int          checked = 0;
   logic        f;             // Pulse catcher

   pmc_regs pmc_regs_i (
      .core_clk(core_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .events(events),
      .block_irq(block_irq), .rx_recovery_bypass(byp),
      .rx_ref_clk(fclk[3]), .tx_ref_clk(fclk[2]), .rx_out_clk(fclk[1]),
      .tx_out_clk(fclk[0]), .ctrl(ctrl), .irq_out_n(irq_out_n));

   // 200 MHz core clock
   always #2.5 core_clk = ~core_clk;

   // Single place that ends the run
   task automatic end_sim;
      if (num_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   // One-cycle write strobe, launched on the falling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      addr = a;
      wr_data = d;
      wr_en = 1'b1;
      @(negedge core_clk);
      wr_en = 1'b0;
   endtask

   // Read with clear strobe; data is registered, so look one edge later
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      addr = a;
      rd_en = 1'b1;
      @(negedge core_clk);
      rd_en = 1'b0;
      chk(rd_data, exp);
   endtask

   // Catch a one-cycle control pulse over a short window
   // Samples first, since a write's pulse already stands when the write task returns
   task automatic catch_pulse(input int which);
      f = 1'b0;
      repeat (4) begin
         f = f | (which == 0 ? ctrl.far_error_insert :
                  which == 1 ? ctrl.force_framer_resync : ctrl.counter_poll);
         @(negedge core_clk);
         events.line_path_err = 1'b0;
      end
   endtask

   // Foreign clocks toggle every two core cycles, then stop low
   task automatic pulse_clk(input logic [3:0] m);
      repeat (8) begin
         tick(2);
         fclk = fclk ^ m;
      end
      tick(4);
   endtask

   task automatic t_reset;
      // Controls leave reset one edge after release
      tick(1);
      chk(ctrl.fixed_pointer_en, 1'b1);
      chk(irq_out_n, 1'b1);
      rdc(OFS_MASTER_CONTROL, 8'h20);
      rdc(OFS_RX_SECT_CTRL, 8'h00);
      rdc(OFS_IRQ_SUMMARY, 8'h00);
   endtask

   task automatic t_config;
      wr(OFS_DEVICE_CONFIG, 8'hff);
      rdc(OFS_DEVICE_CONFIG, 8'h7e);
      chk({ctrl.tx_cell_avail_polarity, ctrl.rx_cell_avail_polarity,
           ctrl.serial_in_polarity}, 3'h7);
      events.line_ais = 1'b1;
      tick(3);
      chk({ctrl.line_defect_insert, ctrl.path_defect_insert}, 2'h3);
      events.line_ais = 1'b0;
      events.ptr_loss = 1'b1;
      tick(3);
      chk({ctrl.line_defect_insert, ctrl.path_defect_insert}, 2'h1);
      events.ptr_loss = 1'b0;
      events.line_path_err = 1'b1;
      catch_pulse(0);
      chk(f, 1'b1);
      // Enables off: alarms and errors must not leak out
      wr(OFS_DEVICE_CONFIG, 8'h00);
      events.signal_loss = 1'b1;
      events.line_path_err = 1'b1;
      catch_pulse(0);
      chk({f, ctrl.line_defect_insert, ctrl.serial_in_polarity}, 3'h0);
      events.signal_loss = 1'b0;
      tick(3);
   endtask

   task automatic t_master;
      wr(OFS_MASTER_CONTROL, 8'h87);
      tick(2);
      chk(ctrl.tx_clk_sel, TXCLK_RECOVERED);
      byp = 1'b1;
      tick(2);
      chk(ctrl.tx_clk_sel, TXCLK_RX_REF);
      byp = 1'b0;
      chk({ctrl.line_loopback_en, ctrl.diag_loopback_en, ctrl.fixed_pointer_en}, 3'h6);
      wr(OFS_MASTER_CONTROL, 8'h86);
      tick(2);
      chk(ctrl.tx_clk_sel, TXCLK_SYNTH);
      // Delineation loss with its enable set pulls the interrupt
      events.cell_delin_loss = 1'b1;
      tick(3);
      chk(irq_out_n, 1'b0);
      rdc(OFS_MASTER_CONTROL, 8'hc6);
      rdc(OFS_IRQ_SUMMARY, 8'h40);
      tick(2);
      chk(irq_out_n, 1'b1);
      rdc(OFS_IRQ_SUMMARY, 8'h00);
      events.cell_delin_loss = 1'b0;
      tick(3);
      rdc(OFS_IRQ_SUMMARY, 8'h40);
      block_irq = 5'h15;
      tick(3);
      rdc(OFS_IRQ_SUMMARY, 8'h15);
      chk(irq_out_n, 1'b0);
      block_irq = 5'h0a;
      tick(3);
      rdc(OFS_IRQ_SUMMARY, 8'h0a);
      block_irq = 5'h00;
      tick(3);
      chk(irq_out_n, 1'b1);
   endtask

   task automatic t_unlock;
      wr(OFS_TX_SYNTH, 8'h03);
      wr(OFS_RX_RECOVERY, 8'h03);
      tick(2);
      chk({ctrl.tx_ref_freq_sel, ctrl.rx_ref_freq_sel}, 2'h3);
      events.tx_unlock = 1'b1;
      tick(3);
      rdc(OFS_TX_SYNTH, 8'h0b);
      chk(irq_out_n, 1'b0);
      rdc(OFS_IRQ_SUMMARY, 8'h80);
      rdc(OFS_IRQ_SUMMARY, 8'h00);
      events.tx_unlock = 1'b0;
      events.rx_unlock = 1'b1;
      tick(3);
      rdc(OFS_RX_RECOVERY, 8'h0b);
      chk(irq_out_n, 1'b0);
      rdc(OFS_IRQ_SUMMARY, 8'h20);
      tick(2);
      chk(irq_out_n, 1'b1);
      events.rx_unlock = 1'b0;
      wr(OFS_TX_SYNTH, 8'h00);
      wr(OFS_RX_RECOVERY, 8'h00);
   endtask

   task automatic t_clocks;
      pulse_clk(4'hf);
      rdc(OFS_CLOCK_ACTIVITY, 8'h0f);
      rdc(OFS_CLOCK_ACTIVITY, 8'h00);
      pulse_clk(4'h1);
      rdc(OFS_CLOCK_ACTIVITY, 8'h01);
      pulse_clk(4'h8);
      rdc(OFS_CLOCK_ACTIVITY, 8'h08);
   endtask

   task automatic t_section;
      wr(OFS_RX_SECT_CTRL, 8'h6f);
      catch_pulse(1);
      chk({f, ctrl.descrambler_disable}, 2'h3);
      rdc(OFS_RX_SECT_CTRL, 8'h4f);
      events.signal_loss = 1'b1;
      tick(3);
      chk(irq_out_n, 1'b0);
      rdc(OFS_RX_SECT_STAT, 8'h24);
      rdc(OFS_RX_SECT_STAT, 8'h04);
      events.frame_loss = 1'b1;
      events.frame_slip = 1'b1;
      tick(3);
      rdc(OFS_RX_SECT_STAT, 8'h1f);
      events = '0;
      tick(3);
      rdc(OFS_RX_SECT_STAT, 8'h38);
      events.ident_err = 1'b1;
      tick(1);
      events.ident_err = 1'b0;
      tick(2);
      rdc(OFS_RX_SECT_STAT, 8'h80);
      wr(OFS_RX_SECT_CTRL, 8'h00);
   endtask

   task automatic t_count;
      wr(OFS_PARITY_CNT_LO, 8'h00);
      repeat (5) begin
         events.parity_err = 1'b1;
         tick(1);
         events.parity_err = 1'b0;
         tick(1);
      end
      rdc(OFS_RX_SECT_STAT, 8'h40);
      wr(OFS_PARITY_CNT_HI, 8'h00);
      rdc(OFS_PARITY_CNT_LO, 8'h05);
      rdc(OFS_PARITY_CNT_HI, 8'h00);
      events.parity_err = 1'b1;
      tick(2);
      // Poll through the master address with an error in the same cycle
      addr = OFS_MASTER_RESET;
      wr_data = 8'h00;
      wr_en = 1'b1;
      tick(1);
      wr_en = 1'b0;
      events.parity_err = 1'b0;
      catch_pulse(2);
      chk(f, 1'b1);
      rdc(OFS_PARITY_CNT_LO, 8'h02);
      wr(OFS_PARITY_CNT_LO, 8'h00);
      rdc(OFS_PARITY_CNT_LO, 8'h01);
      wr(OFS_MASTER_RESET, 8'h80);
      tick(2);
      chk(ctrl.framing_reset, 1'b1);
      wr(OFS_MASTER_RESET, 8'h00);
      tick(2);
      chk(ctrl.framing_reset, 1'b0);
      // Unmapped and read-only places ignore writes
      wr(8'h08, 8'hff);
      rdc(8'h08, 8'h00);
      wr(OFS_RX_SECT_STAT, 8'hff);
      rdc(OFS_RX_SECT_STAT, 8'h40);
   endtask

   // Hang guard
   initial begin
      #100us;
      num_errors++;
      end_sim();
   end

   initial begin
      repeat (8) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      t_reset();
      t_config();
      t_master();
      t_unlock();
      t_clocks();
      t_section();
      t_count();
      end_sim();
   end
endmodule
